/* design/tec_edge_det.sv */
// Sampled edge detector with two-sample noise filter for one timer input.
// Assumes the pin is synchronous to hclk and sample is a one-cycle pulse.
`timescale 1ns/100ps
module tec_edge_det (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sample,
  input wire logic enable,
  input wire logic [1:0] sel,
  input wire logic pin,
  tec_edge_if.det ev
);
  typedef struct packed {
    logic last;
    logic filt;
    logic rise;
    logic fall;
    logic valid;
  } tec_edge_state_type;
  tec_edge_state_type r, next_r;
  logic change;

  // A level counts only after two equal samples; short glitches never reach filt.
  always_comb begin
    next_r = r;
    next_r.rise = 1'b0;
    next_r.fall = 1'b0;
    next_r.valid = 1'b0;
    change = sample && (pin == r.last) && (pin != r.filt); // RULE_07
    if (sample) begin
      next_r.last = pin;
    end
    if (change) begin
      next_r.filt = pin;
      // Edges while stopped update the level but are not reported.
      if (enable) begin
        next_r.rise = pin;
        next_r.fall = !pin;
        unique case (sel) // RULE_09
          tec_pkg::EDGE_FALL: next_r.valid = !pin;
          tec_pkg::EDGE_RISE: next_r.valid = pin;
          tec_pkg::EDGE_BOTH: next_r.valid = 1'b1;
          default: next_r.valid = 1'b0; // RULE_02
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ev.rise = r.rise;
  assign ev.fall = r.fall;
  assign ev.valid = r.valid;

  // A new level is taken only when it matched the previous sample.
  sequence s_two_samples;
    sample && pin == r.last;
  endsequence
  a_filter_two_samples: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    (r.filt != next_r.filt) |-> s_two_samples)
    else $error("filtered level changed without two equal samples");
endmodule // tec_edge_det

/* design/tec_edge_if.sv */
// Edge events from one input detector to the timer core.
// Assumes all signals are in the bus clock domain.
`timescale 1ns/100ps
interface tec_edge_if;
  logic rise;
  logic fall;
  logic valid;
  modport det (output rise, output fall, output valid);
  modport use_side (input rise, input fall, input valid);
endinterface // tec_edge_if

/* design/tec_pkg.sv */
// Constants, register map and field layout of the 16-bit timer/event counter.
// Assumes a single 20 MHz bus clock; all slower rates are enable pulses.
// Overview of operation
// RULE_01 - Interval mode clears on match A, interrupts
// RULE_02 - Edge codes: 00 fall, 01 rise, 11 both
// RULE_03 - Pulse mode: period from A, width from B
// RULE_04 - Software keeps compare B below compare A
// RULE_05 - Period A+1 clocks, active width B+1
// RULE_06 - Input A edge captures count into B
// RULE_07 - Edge needs two equal samples on count clock
// RULE_08 - Input B edge captures count into A
// RULE_09 - Each input selects rising, falling or both
// RULE_10 - Opposite input A edge captures into A
// RULE_11 - No opposite-edge capture when both edges selected
// RULE_12 - Restart mode: capture into B, then clear
// RULE_13 - Event mode counts valid input A edges
// RULE_14 - Event mode clears on match A, interrupts
// RULE_15 - Output toggles on match A when enabled
// RULE_16 - First match may come one count clock late
// RULE_17 - Software never writes zero to compare registers
// RULE_18 - Lowered compare A wraps through overflow first
// RULE_19 - Software restarts timer after lowering compare A
// RULE_20 - Capture still happens and flags during read
// RULE_21 - Software reads event count from counter
// RULE_22 - Pulse output active from zero until B
package tec_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PRESC = 8'h04;
  localparam logic [7:0] OFS_CCCTL = 8'h08;
  localparam logic [7:0] OFS_OUTCTL = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_CCA = 8'h14;
  localparam logic [7:0] OFS_CCB = 8'h18;
  // Run modes held in the low two bits of the mode register.
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_FREE = 2'h1;
  localparam logic [1:0] MODE_RESTART = 2'h2;
  localparam logic [1:0] MODE_CLEAR_A = 2'h3;
  // Edge select codes.
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BAD = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Count clock select codes.
  localparam logic [1:0] CLK_EXT_A = 2'h3;
  // Field positions.
  localparam int PRESC_EA_LSB = 4;
  localparam int PRESC_EB_LSB = 6;
  localparam int CC_A_CAP = 0;
  localparam int CC_A_REV = 1;
  localparam int CC_B_CAP = 2;
  localparam int OUT_EN = 0;
  localparam int OUT_TOG_A = 1;
  localparam int OUT_CLR = 2;
  localparam int OUT_SET = 3;
  localparam int OUT_TOG_B = 4;
  // Values after reset.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_CC = 16'h0000;
  // Count clock dividers in bus clock cycles.
  localparam int DIV_0 = 2;
  localparam int DIV_1 = 16;
  localparam int DIV_2 = 128;
endpackage

/* design/tec_presc.sv */
// Count clock divider producing a one-cycle tick enable.
// Assumes the select is changed only while the timer is stopped.
`timescale 1ns/100ps
module tec_presc #(
  parameter int DIV0 = tec_pkg::DIV_0,
  parameter int DIV1 = tec_pkg::DIV_1,
  parameter int DIV2 = tec_pkg::DIV_2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] sel,
  output logic tick
);
  localparam int CW = $clog2(DIV2);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tec_presc_state_type;
  tec_presc_state_type r, next_r;
  logic [CW-1:0] last;

  // The divider runs free, so the timer start is not aligned to a tick.
  always_comb begin
    unique case (sel)
      2'h0: last = CW'(DIV0 - 1);
      2'h1: last = CW'(DIV1 - 1);
      2'h2: last = CW'(DIV2 - 1);
      default: last = '0;
    endcase
    next_r = r;
    next_r.tick = (r.cnt >= last);
    next_r.cnt = (r.cnt >= last) ? '0 : CW'(r.cnt + 1'b1);
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule // tec_presc

/* design/tec_timer.sv */
// Top of the 16-bit timer/event counter with two capture/compare registers.
// Assumes one AHB-Lite master, word accesses only, and inputs synchronous to hclk.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module tec_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pulse_input_a,
  input wire logic pulse_input_b,
  output logic timer_output_pin,
  output logic timer_output_oe,
  output logic match_a_irq,
  output logic capture_b_irq
);
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic [7:0] timer_mode_reg;
    logic [7:0] prescaler_edge_reg;
    logic [7:0] cmp_cap_control_reg;
    logic [7:0] output_control_reg;
    logic [15:0] running_count;
    logic [15:0] cmp_cap_reg_a;
    logic [15:0] cmp_cap_reg_b;
    logic out_ff;
    logic pin;
    logic oe;
    logic match_a_irq;
    logic capture_b_irq;
  } tec_timer_state_type;
  tec_timer_state_type r, next_r;

  tec_edge_if ea ();
  tec_edge_if eb ();
  logic presc_tick;
  logic [1:0] mode;
  logic [1:0] clk_sel;
  logic [1:0] esel_a;
  logic [1:0] esel_b;
  logic running;
  logic tick;
  logic ma;
  logic mb;
  logic programmable_pulse_gen;
  logic trig_a;

  assign mode = r.timer_mode_reg[1:0];
  assign clk_sel = r.prescaler_edge_reg[1:0];
  assign esel_a = r.prescaler_edge_reg[tec_pkg::PRESC_EA_LSB +: 2];
  assign esel_b = r.prescaler_edge_reg[tec_pkg::PRESC_EB_LSB +: 2];
  assign running = (mode != tec_pkg::MODE_STOP);

  // Divider for the internal count clock; in external mode it samples every cycle.
  tec_presc u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(clk_sel),
    .tick(presc_tick)
  );

  // Both inputs are sampled on the divider tick, which comes every bus cycle in external mode.
  tec_edge_det u_edge_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(presc_tick),
    .enable(running),
    .sel(esel_a),
    .pin(pulse_input_a),
    .ev(ea.det)
  );

  tec_edge_det u_edge_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(presc_tick),
    .enable(running),
    .sel(esel_b),
    .pin(pulse_input_b),
    .ev(eb.det)
  );

  // Count enable and compare decode; compares act only on count clock ticks.
  always_comb begin
    tick = running && ((clk_sel == tec_pkg::CLK_EXT_A) ? ea.valid : presc_tick); // RULE_13
    // Equality only: a compare lowered below the count is met after wrap-around.
    ma = tick && (r.running_count == r.cmp_cap_reg_a) && !r.cmp_cap_control_reg[tec_pkg::CC_A_CAP]; // RULE_18
    mb = tick && (r.running_count == r.cmp_cap_reg_b) && !r.cmp_cap_control_reg[tec_pkg::CC_B_CAP];
    programmable_pulse_gen = (mode == tec_pkg::MODE_CLEAR_A) && r.output_control_reg[tec_pkg::OUT_TOG_A]
      && r.output_control_reg[tec_pkg::OUT_TOG_B]; // RULE_03
    // The opposite-edge trigger is meaningless when both edges are valid.
    if (r.cmp_cap_control_reg[tec_pkg::CC_A_REV]) begin
      trig_a = (esel_a == tec_pkg::EDGE_RISE) ? ea.fall
        : (esel_a == tec_pkg::EDGE_FALL) ? ea.rise : 1'b0; // RULE_10 RULE_11
    end else begin
      trig_a = eb.valid; // RULE_08
    end
  end

  // Bus slave, counter, captures and output flip-flop in one next-state process.
  always_comb begin
    next_r = r;
    next_r.match_a_irq = 1'b0;
    next_r.capture_b_irq = 1'b0;
    next_r.output_control_reg[tec_pkg::OUT_CLR] = 1'b0;
    next_r.output_control_reg[tec_pkg::OUT_SET] = 1'b0;
    // Address phase: read data is fetched now so hrdata comes from a flop with no wait.
    next_r.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_r.wr_pend = hwrite;
      next_r.wr_addr = haddr[7:0];
      next_r.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[7:0])
          tec_pkg::OFS_MODE: next_r.hrdata[7:0] = r.timer_mode_reg;
          tec_pkg::OFS_PRESC: next_r.hrdata[7:0] = r.prescaler_edge_reg;
          tec_pkg::OFS_CCCTL: next_r.hrdata[7:0] = r.cmp_cap_control_reg;
          tec_pkg::OFS_OUTCTL: next_r.hrdata[7:0] = r.output_control_reg;
          tec_pkg::OFS_COUNT: next_r.hrdata[15:0] = r.running_count;
          tec_pkg::OFS_CCA: next_r.hrdata[15:0] = r.cmp_cap_reg_a;
          tec_pkg::OFS_CCB: next_r.hrdata[15:0] = r.cmp_cap_reg_b;
          default: next_r.hrdata = 32'h0000_0000;
        endcase
      end
    end
    // Data phase of a write; unmapped offsets are ignored with an OKAY answer.
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        tec_pkg::OFS_MODE: next_r.timer_mode_reg = {6'h00, hwdata[1:0]};
        tec_pkg::OFS_PRESC: next_r.prescaler_edge_reg = {hwdata[7:4], 2'h0, hwdata[1:0]};
        tec_pkg::OFS_CCCTL: next_r.cmp_cap_control_reg = {5'h00, hwdata[2:0]};
        tec_pkg::OFS_OUTCTL: begin
          next_r.output_control_reg = {3'h0, hwdata[4], 2'h0, hwdata[1:0]};
          if (hwdata[tec_pkg::OUT_CLR] && !hwdata[tec_pkg::OUT_SET]) begin
            next_r.out_ff = 1'b0;
          end
          if (hwdata[tec_pkg::OUT_SET] && !hwdata[tec_pkg::OUT_CLR]) begin
            next_r.out_ff = 1'b1;
          end
        end
        tec_pkg::OFS_CCA: next_r.cmp_cap_reg_a = hwdata[15:0];
        tec_pkg::OFS_CCB: next_r.cmp_cap_reg_b = hwdata[15:0];
        default: next_r.hrdata = r.hrdata;
      endcase
    end
    // The counter holds zero while stopped and starts on the next divider tick, or on the next valid input A edge in external mode.
    if (!running) begin
      next_r.running_count = tec_pkg::RST_COUNT;
    end else if (tick) begin
      if (ma && mode == tec_pkg::MODE_CLEAR_A) begin
        next_r.running_count = 16'h0000; // RULE_01 RULE_14 RULE_16
      end else begin
        next_r.running_count = 16'(r.running_count + 16'h0001);
      end
    end
    // Match A drives the interrupt pulse; both compare events drive the output flip-flop.
    if (ma) begin
      next_r.match_a_irq = 1'b1; // RULE_01 RULE_14
    end
    if (programmable_pulse_gen) begin
      if (ma) begin
        next_r.out_ff = 1'b1; // RULE_22 RULE_05
      end else if (mb) begin
        next_r.out_ff = 1'b0; // RULE_22 RULE_05
      end
    end else begin
      if ((ma && r.output_control_reg[tec_pkg::OUT_TOG_A]) != (mb && r.output_control_reg[tec_pkg::OUT_TOG_B])) begin
        next_r.out_ff = !r.out_ff; // RULE_15
      end
    end
    // Captures come last so they win over a bus write in the same cycle.
    if (running && ea.valid) begin
      if (mode == tec_pkg::MODE_RESTART) begin
        next_r.cmp_cap_reg_b = r.running_count; // RULE_12
        next_r.running_count = 16'h0000; // RULE_12
        next_r.capture_b_irq = 1'b1;
      end else if (r.cmp_cap_control_reg[tec_pkg::CC_B_CAP]) begin
        next_r.cmp_cap_reg_b = r.running_count; // RULE_06 RULE_20
        next_r.capture_b_irq = 1'b1; // RULE_06 RULE_20
      end
    end
    if (running && r.cmp_cap_control_reg[tec_pkg::CC_A_CAP] && trig_a) begin
      next_r.cmp_cap_reg_a = r.running_count; // RULE_08 RULE_10
      next_r.match_a_irq = 1'b1; // RULE_08
    end
    next_r.pin = r.output_control_reg[tec_pkg::OUT_EN] && next_r.out_ff;
    next_r.oe = r.output_control_reg[tec_pkg::OUT_EN];
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.timer_mode_reg <= tec_pkg::RST_CTRL;
      r.prescaler_edge_reg <= tec_pkg::RST_CTRL;
      r.cmp_cap_control_reg <= tec_pkg::RST_CTRL;
      r.output_control_reg <= tec_pkg::RST_CTRL;
      r.running_count <= tec_pkg::RST_COUNT;
      r.cmp_cap_reg_a <= tec_pkg::RST_CC;
      r.cmp_cap_reg_b <= tec_pkg::RST_CC;
    end else begin
      r <= next_r;
    end
  end

  // Ready is a constant flop and the response is tied low: every transfer is zero-wait OKAY.
  logic ready_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= 1'b1;
    end
  end

  assign hreadyout = ready_q;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign timer_output_pin = r.pin;
  assign timer_output_oe = r.oe;
  assign match_a_irq = r.match_a_irq;
  assign capture_b_irq = r.capture_b_irq;

  // Checks on the counting, capture and output behaviour.
  sequence s_clear_match;
    tick && mode == tec_pkg::MODE_CLEAR_A && ma;
  endsequence
  sequence s_cleared;
    r.running_count == 16'h0000 && r.match_a_irq;
  endsequence
  a_clear_on_match: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    s_clear_match and !(ea.valid && mode == tec_pkg::MODE_RESTART) |=> s_cleared)
    else $error("count not cleared with match A interrupt");
  a_bad_code_silent: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    (esel_a == tec_pkg::EDGE_BAD) [*2] |-> !ea.valid)
    else $error("prohibited edge code produced an edge");
  a_ppg_active_low: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_22
    programmable_pulse_gen && mb && !ma && !r.wr_pend |=> !r.out_ff ##1 (r.pin == 1'b0))
    else $error("pulse output not inactive after compare B");
  a_ppg_active_high: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    programmable_pulse_gen && ma && !r.wr_pend |=> r.out_ff)
    else $error("pulse output not active at restart from zero");
  a_capture_b_edge: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    running && ea.valid && r.cmp_cap_control_reg[tec_pkg::CC_B_CAP]
    |=> r.cmp_cap_reg_b == $past(r.running_count) && r.capture_b_irq)
    else $error("input A edge did not capture into B");
  a_capture_a_input_b: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
    running && eb.valid && r.cmp_cap_control_reg[tec_pkg::CC_A_CAP] && !r.cmp_cap_control_reg[tec_pkg::CC_A_REV]
    |=> r.cmp_cap_reg_a == $past(r.running_count) && r.match_a_irq)
    else $error("input B edge did not capture into A");
  a_no_rev_both: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    esel_a == tec_pkg::EDGE_BOTH && r.cmp_cap_control_reg[tec_pkg::CC_A_REV] && !r.wr_pend
    |=> $stable(r.cmp_cap_reg_a))
    else $error("opposite-edge capture ran with both edges selected");
  a_restart_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
    mode == tec_pkg::MODE_RESTART && running && ea.valid
    |=> r.running_count == 16'h0000 && r.cmp_cap_reg_b == $past(r.running_count))
    else $error("restart capture did not clear the counter");
  a_event_step: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
    running && mode != tec_pkg::MODE_RESTART && clk_sel == tec_pkg::CLK_EXT_A
    && !(ma && mode == tec_pkg::MODE_CLEAR_A) && !r.wr_pend
    |=> r.running_count == 16'($past(r.running_count) + {15'h0000, $past(ea.valid)}))
    else $error("event count did not follow input A edges");
  a_square_toggle: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15
    ma && r.output_control_reg[tec_pkg::OUT_TOG_A] && !r.output_control_reg[tec_pkg::OUT_TOG_B] && !r.wr_pend
    |=> r.out_ff != $past(r.out_ff))
    else $error("output did not toggle on match A");
endmodule // tec_timer

/* dv/tec_pulse_src.sv */
// Model of the two external pulse sources feeding the timer inputs.
// Assumes the bench clock is hclk and that levels change just after a rising edge.
`timescale 1ns/100ps
module tec_pulse_src (
  input wire logic hclk,
  input wire logic out_pin,
  input wire logic out_oe,
  output logic pin_a,
  output logic pin_b
);
  logic line_level;

  // Both sources idle low, so no spurious rising edge is seen when the timer starts.
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // The output line is weakly pulled low whenever the timer does not drive it.
  assign line_level = out_oe ? out_pin : 1'b0;

  // A level is held for a whole number of bus cycles; real sources hold eight,
  // four samples at the fastest divider, so the noise filter never drops them.
  task automatic drive(input bit sel_b, input logic lvl, input int hold);
    @(posedge hclk);
    if (sel_b) begin
      pin_b <= lvl;
    end else begin
      pin_a <= lvl;
    end
    repeat (hold) @(posedge hclk);
  endtask
endmodule // tec_pulse_src

/* dv/timer_event_counter_modes_test.sv */
// Self-checking bench for the timer: AHB-Lite register tasks and mode scenarios.
// Assumes the design files and the pulse source model are compiled first.
`timescale 1ns/100ps
module timer_event_counter_modes_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pulse_input_a, pulse_input_b, timer_output_pin, timer_output_oe, match_a_irq, capture_b_irq;
  int bad_count, checks_done, na, nb;

  tec_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pulse_input_a(pulse_input_a), .pulse_input_b(pulse_input_b),
    .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .match_a_irq(match_a_irq), .capture_b_irq(capture_b_irq));
  tec_pulse_src src (.hclk(hclk), .out_pin(timer_output_pin), .out_oe(timer_output_oe),
    .pin_a(pulse_input_a), .pin_b(pulse_input_b));

  // The single slave answers for the whole bus.
  assign hready = hreadyout;

  // A 50 ns clock for the 20 MHz bus.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Interrupt pulses are counted at the falling edge, where they are settled.
  always @(negedge hclk) begin
    if (match_a_irq === 1'b1) na++;
    if (capture_b_irq === 1'b1) nb++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Address phase is held until hready is seen high, then the data phase likewise.
  task automatic bus(input logic [7:0] a, input logic wr_en, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr_en;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(a, 1'b1, d, unused);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0000_0000, q);
  endtask

  // Control registers are only rewritten while the timer is stopped.
  task automatic cfg(input logic [31:0] mode, input logic [31:0] presc, input logic [31:0] cc,
                     input logic [31:0] outc);
    wr(tec_pkg::OFS_MODE, 32'h0000_0000);
    wr(tec_pkg::OFS_PRESC, presc);
    wr(tec_pkg::OFS_CCCTL, cc);
    wr(tec_pkg::OFS_OUTCTL, outc);
    wr(tec_pkg::OFS_MODE, mode);
  endtask

  // Counts falling edges until the output pin or the match pulse shows the level.
  task automatic gap(input bit use_irq, input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (((use_irq ? match_a_irq : timer_output_pin) !== lvl) && n < 3000);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // Main sequence; outside the interval and event tests every compare value follows from the divide-by-2 count clock.
  initial begin
    logic [31:0] v, c0, c1;
    int n, n2, a0, b0;
    int exp_cap[4];
    exp_cap = '{1, 1, 0, 2};
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), v);
      check(v, 32'h0000_0000);
    end
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, v);
    check(v, 32'h0000_0000);
    check({30'h0000_0000, hresp, hreadyout}, 32'h0000_0001);
    check({31'h0000_0000, src.line_level}, 32'h0000_0000);
    end_test("reset");
    // Compare rewrites are made with the timer stopped or running, never with zero compares.
    wr(tec_pkg::OFS_CCA, 32'h0000_0009);
    rd(tec_pkg::OFS_CCA, v);
    check(v, 32'h0000_0009);
    // Every count clock divider is tried; one period is A+1 count clocks.
    for (int k = 0; k < 3; k++) begin
      cfg(32'h0000_0003, 32'(k), 32'h0000_0000, 32'h0000_0000);
      gap(1'b1, 1'b1, n);
      gap(1'b1, 1'b1, n);
      n2 = (k == 0) ? tec_pkg::DIV_0 : (k == 1) ? tec_pkg::DIV_1 : tec_pkg::DIV_2;
      check(32'(n), 32'(10 * n2));
    end
    end_test("interval");
    wr(tec_pkg::OFS_CCA, 32'h0000_0004);
    cfg(32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 32'h0000_0007);
    gap(1'b0, ~timer_output_pin, n);
    gap(1'b0, ~timer_output_pin, n);
    check(32'(n), 32'h0000_000A);
    check({31'h0000_0000, timer_output_oe}, 32'h0000_0001);
    end_test("square");
    wr(tec_pkg::OFS_CCA, 32'h0000_0009);
    wr(tec_pkg::OFS_CCB, 32'h0000_0003);
    cfg(32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 32'h0000_0017);
    gap(1'b0, 1'b0, n);
    gap(1'b0, 1'b1, n);
    gap(1'b0, 1'b0, n);
    gap(1'b0, 1'b1, n2);
    check(32'(n), 32'h0000_0008);
    check(32'(n + n2), 32'h0000_0014);
    end_test("pulse generator");
    for (int code = 0; code < 4; code++) begin
      cfg(32'h0000_0001, 32'(code << 4), 32'h0000_0004, 32'h0000_0000);
      b0 = nb;
      rd(tec_pkg::OFS_COUNT, c0);
      src.drive(1'b0, 1'b1, 8);
      rd(tec_pkg::OFS_CCB, v);
      rd(tec_pkg::OFS_COUNT, c1);
      if (code == 1) check({31'h0000_0000, v >= c0 && v <= c1}, 32'h0000_0001);
      src.drive(1'b0, 1'b0, 8);
      check(32'(nb - b0), 32'(exp_cap[code]));
    end
    end_test("edge select");
    cfg(32'h0000_0001, 32'h0000_0010, 32'h0000_0004, 32'h0000_0000);
    b0 = nb;
    src.drive(1'b0, 1'b1, 1);
    src.drive(1'b0, 1'b0, 40);
    check(32'(nb - b0), 32'h0000_0000);
    end_test("noise");
    cfg(32'h0000_0001, 32'h0000_0050, 32'h0000_0005, 32'h0000_0000);
    a0 = na;
    b0 = nb;
    src.drive(1'b1, 1'b1, 8);
    src.drive(1'b1, 1'b0, 8);
    check(32'(na - a0), 32'h0000_0001);
    check(32'(nb - b0), 32'h0000_0000);
    end_test("two pulses");
    for (int both = 0; both < 2; both++) begin
      cfg(32'h0000_0001, both ? 32'h0000_0030 : 32'h0000_0010, 32'h0000_0007, 32'h0000_0000);
      a0 = na;
      b0 = nb;
      src.drive(1'b0, 1'b1, 8);
      src.drive(1'b0, 1'b0, 8);
      check(32'(nb - b0), both ? 32'h0000_0002 : 32'h0000_0001);
      check(32'(na - a0), both ? 32'h0000_0000 : 32'h0000_0001);
    end
    end_test("two registers");
    cfg(32'h0000_0002, 32'h0000_0010, 32'h0000_0004, 32'h0000_0000);
    repeat (100) @(posedge hclk);
    b0 = nb;
    src.drive(1'b0, 1'b1, 8);
    rd(tec_pkg::OFS_CCB, v);
    rd(tec_pkg::OFS_COUNT, c1);
    src.drive(1'b0, 1'b0, 8);
    check(32'(nb - b0), 32'h0000_0001);
    check({31'h0000_0000, v > c1 && v > 32'h0000_0028}, 32'h0000_0001);
    end_test("restart");
    wr(tec_pkg::OFS_CCA, 32'h0000_0003);
    cfg(32'h0000_0003, 32'h0000_0013, 32'h0000_0000, 32'h0000_0000);
    repeat (2) begin
      src.drive(1'b0, 1'b1, 8);
      src.drive(1'b0, 1'b0, 8);
    end
    rd(tec_pkg::OFS_COUNT, v);
    check(v, 32'h0000_0002);
    a0 = na;
    for (int i = 0; i < 4 && na == a0; i++) begin
      src.drive(1'b0, 1'b1, 8);
      src.drive(1'b0, 1'b0, 8);
    end
    a0 = na;
    repeat (4) begin
      src.drive(1'b0, 1'b1, 8);
      src.drive(1'b0, 1'b0, 8);
    end
    check(32'(na - a0), 32'h0000_0001);
    end_test("event counter");
    wr(tec_pkg::OFS_CCA, 32'h0000_03E8);
    cfg(32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    repeat (100) @(posedge hclk);
    wr(tec_pkg::OFS_CCA, 32'h0000_000A);
    a0 = na;
    repeat (300) @(posedge hclk);
    rd(tec_pkg::OFS_COUNT, v);
    check(32'(na - a0), 32'h0000_0000);
    check({31'h0000_0000, v > 32'h0000_000A}, 32'h0000_0001);
    wr(tec_pkg::OFS_MODE, 32'h0000_0000);
    end_test("lowered compare");
    // Software clear and set of the output flip-flop; the command bits read back as 0.
    wr(tec_pkg::OFS_OUTCTL, 32'h0000_0005);
    repeat (2) @(negedge hclk);
    check({31'h0000_0000, timer_output_pin}, 32'h0000_0000);
    wr(tec_pkg::OFS_OUTCTL, 32'h0000_0009);
    repeat (2) @(negedge hclk);
    check({31'h0000_0000, timer_output_pin}, 32'h0000_0001);
    check({31'h0000_0000, src.line_level}, 32'h0000_0001);
    rd(tec_pkg::OFS_OUTCTL, v);
    check(v, 32'h0000_0001);
    end_test("output set");
    close_out();
  end

  // The whole run needs some 4200 cycles; 20000 means the bench is stuck.
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    close_out();
  end
endmodule // timer_event_counter_modes_test
